// ==== split_timer_pkg.sv ====
// shared constants and types for the split-mode dual byte timer
package split_timer_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_TIMER_CONTROL = 6'h00;
   localparam logic [5:0] IDX_SPLIT_CONFIG = 6'h03;
   localparam logic [5:0] IDX_COMMAND_CLEAR_VIEW = 6'h04;
   localparam logic [5:0] IDX_COMMAND_SET_VIEW = 6'h05;
   localparam logic [5:0] IDX_INTERRUPT_ENABLE = 6'h0A;
   localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h0B;
   localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h0E;
   localparam logic [5:0] IDX_LOW_COUNTER = 6'h20;
   localparam logic [5:0] IDX_HIGH_COUNTER = 6'h21;
   localparam logic [5:0] IDX_LOW_PERIOD = 6'h26;
   localparam logic [5:0] IDX_HIGH_PERIOD = 6'h27;
   localparam logic [5:0] IDX_LOW_COMPARE0 = 6'h28;
   localparam logic [5:0] IDX_COMPARE_STRIDE = 6'h02;

   // field positions
   localparam int BIT_ENABLE = 0;
   localparam int CLKSEL_LSB = 1;
   localparam int BIT_SPLIT_ENABLE = 0;
   localparam int CMD_LSB = 2;
   localparam int TARGET_LSB = 0;
   localparam int BIT_LOW_COMPARE0 = 4;
   localparam int BIT_HIGH_UNDERFLOW = 1;
   localparam int BIT_LOW_UNDERFLOW = 0;
   localparam int BIT_RUN_IN_DEBUG = 0;
   localparam int COMPARE_CHANNELS = 3;

   // implemented bits of the enable and flag registers
   localparam logic [7:0] INTERRUPT_BIT_MASK = 8'h73;

   // values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [9:0] PRESCALE_RESET = 10'h000;
   localparam logic [31:0] READ_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_RESERVED = 2'b01,
      CMD_RESTART = 2'b10,
      CMD_HARD_RESET = 2'b11
   } command_t;

   localparam logic [1:0] TARGET_NONE = 2'b00;
   localparam logic [1:0] TARGET_BOTH = 2'b11;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;

endpackage : split_timer_pkg

// ==== byte_down_counter.sv ====
// one 8-bit down-counter with period reload and write priority
`timescale 1ns/10ps
module byte_down_counter
   import split_timer_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // control
   input wire logic tick,
   input wire logic clear,
   input wire logic [7:0] period,
   // software access
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // status
   output logic [7:0] count,
   output logic bottom
);

   logic [7:0] count_reg;
   logic [7:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (wr_en) begin
         count_next = wr_data;
      end else if (clear) begin
         count_next = BYTE_RESET;
      end else if (tick) begin
         if (count_reg == BYTE_RESET) begin
            count_next = period;
         end else begin
            count_next = count_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count_reg <= BYTE_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // underflow counts only if the hardware update really happens
   assign bottom = tick & ~wr_en & ~clear & (count_reg == BYTE_RESET);
   assign count = count_reg;

endmodule : byte_down_counter

// ==== split_mode_dual_byte_timer_ctrl.sv ====
// split-mode dual byte timer: registers, commands, flags, counters
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
//
// Contract
// - split enable set runs two independent 8-bit timers, low and high
// - split enable switches to the split register layout
// - clear view write clears target bits written one, others kept
// - set view write sets target bits written one, others kept
// - command field bits 3:2 always read zero in both views
// - command 0 none, 1 reserved, 2 restart, 3 hard reset
// - hard reset ignored while enabled, done only while disabled
// - target 0 none, 1 and 2 reserved, 3 both byte timers
// - interrupt enables: compare 2..0 in bits 6:4, underflows bits 1:0
// - low compare flag n sets when low counter equals compare n
// - flags clear only by software writing one to the bit, or by a hard reset command
// - high underflow flag bit 1 sets at high timer bottom
// - low underflow flag bit 0 sets at low timer bottom
// - run-in-debug 0 halts and ignores events in break, 1 runs on
// - low counter readable and writable at 0x20, resets to zero
// - software counter write beats count, clear or reload
// - period registers at 0x26 and 0x27 hold top, reset all ones
// - three low compare values at 0x28 plus 2n compared every cycle the timer is running
// - high counter readable and writable at 0x21, resets to zero
module split_mode_dual_byte_timer_ctrl
   import split_timer_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // debug
   input wire logic cpu_debug_halted,
   // timer status
   output logic [7:0] low_counter_value,
   output logic [7:0] high_counter_value,
   output logic [4:0] interrupt_request
);

   // true when idx addresses low compare channel ch
   function automatic logic compare_hit(input logic [5:0] idx,
                                        input int ch);
      logic [5:0] target;
      target = IDX_LOW_COMPARE0 + IDX_COMPARE_STRIDE * ch[5:0];
      compare_hit = (idx == target);
   endfunction : compare_hit

   // prescaler mask, divider minus one
   function automatic logic [9:0] prescale_mask(input logic [2:0] sel);
      case (sel)
         3'h0: prescale_mask = 10'h000;
         3'h1: prescale_mask = 10'h001;
         3'h2: prescale_mask = 10'h003;
         3'h3: prescale_mask = 10'h007;
         3'h4: prescale_mask = 10'h00F;
         3'h5: prescale_mask = 10'h03F;
         3'h6: prescale_mask = 10'h0FF;
         default: prescale_mask = 10'h3FF;
      endcase
   endfunction : prescale_mask

   // registers
   bus_state_t bus_state_reg;
   bus_state_t bus_state_next;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic enable_reg;
   logic enable_next;
   logic [2:0] clksel_reg;
   logic [2:0] clksel_next;
   logic split_enable_reg;
   logic split_enable_next;
   logic [1:0] target_reg;
   logic [1:0] target_next;
   logic [7:0] int_enable_reg;
   logic [7:0] int_enable_next;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic run_in_debug_reg;
   logic run_in_debug_next;
   logic [7:0] low_period_reg;
   logic [7:0] low_period_next;
   logic [7:0] high_period_reg;
   logic [7:0] high_period_next;
   logic [7:0] compare_reg [COMPARE_CHANNELS];
   logic [7:0] compare_next [COMPARE_CHANNELS];
   logic [9:0] prescale_reg;
   logic [9:0] prescale_next;
   logic [4:0] irq_reg;
   logic [4:0] irq_next;

   // decode and timer control
   logic [5:0] idx;
   logic [7:0] wdata;
   logic bus_ack;
   logic wr;
   logic split_map;
   logic running;
   logic tick;
   command_t command;
   logic restart_cmd;
   logic hard_reset_cmd;
   logic [7:0] rd_byte;
   logic [7:0] low_count;
   logic [7:0] high_count;
   logic low_bottom;
   logic high_bottom;
   logic [7:0] flag_set;
   logic [7:0] flag_clear;

   assign idx = avs_address[7:2];
   assign wdata = avs_writedata[7:0];
   assign bus_ack = (bus_state_reg == BUS_ANSWER);
   assign wr = avs_write & bus_ack & avs_byteenable[0];
   assign split_map = split_enable_reg;

   // halted in break unless told to run on
   assign running = enable_reg & split_enable_reg
      & (~cpu_debug_halted | run_in_debug_reg);
   assign tick = running
      & ((prescale_reg & prescale_mask(clksel_reg))
         == prescale_mask(clksel_reg));

   // commands come only from a set-view write
   always_comb begin
      command = CMD_NONE;
      if (wr && split_map && idx == IDX_COMMAND_SET_VIEW) begin
         command = command_t'(wdata[CMD_LSB+1:CMD_LSB]);
      end
   end

   // the new target selection applies to the command in the same write
   assign restart_cmd = (command == CMD_RESTART)
      && (target_next == TARGET_BOTH);
   assign hard_reset_cmd = (command == CMD_HARD_RESET)
      && (target_next == TARGET_BOTH) && !enable_reg;

   // bus handshake: one wait cycle, then the answer
   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         BUS_IDLE: begin
            if (avs_read | avs_write) begin
               bus_state_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            bus_state_next = BUS_IDLE;
         end
         default: begin
            bus_state_next = BUS_IDLE;
         end
      endcase
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

   // read mux; unmapped and hidden offsets read zero
   always_comb begin
      rd_byte = BYTE_RESET;
      case (idx)
         IDX_TIMER_CONTROL: begin
            rd_byte[BIT_ENABLE] = enable_reg;
            rd_byte[CLKSEL_LSB+2:CLKSEL_LSB] = clksel_reg;
         end
         IDX_SPLIT_CONFIG: begin
            rd_byte[BIT_SPLIT_ENABLE] = split_enable_reg;
         end
         IDX_DEBUG_CONTROL: begin
            rd_byte[BIT_RUN_IN_DEBUG] = run_in_debug_reg;
         end
         default: begin
            rd_byte = BYTE_RESET;
         end
      endcase
      if (split_map) begin
         case (idx)
            IDX_COMMAND_CLEAR_VIEW, IDX_COMMAND_SET_VIEW: begin
               // command bits are never stored, so they read zero
               rd_byte[TARGET_LSB+1:TARGET_LSB] = target_reg;
            end
            IDX_INTERRUPT_ENABLE: rd_byte = int_enable_reg;
            IDX_INTERRUPT_FLAGS: rd_byte = flags_reg;
            IDX_LOW_COUNTER: rd_byte = low_count;
            IDX_HIGH_COUNTER: rd_byte = high_count;
            IDX_LOW_PERIOD: rd_byte = low_period_reg;
            IDX_HIGH_PERIOD: rd_byte = high_period_reg;
            default: begin
               for (int n = 0; n < COMPARE_CHANNELS; n++) begin
                  if (compare_hit(idx, n)) begin
                     rd_byte = compare_reg[n];
                  end
               end
            end
         endcase
      end
   end

   // readdata captured in the wait cycle, stands at the answer edge
   always_comb begin
      readdata_next = readdata_reg;
      if (avs_read && !bus_ack) begin
         readdata_next = {24'h000000, rd_byte};
      end
   end

   // control and configuration registers
   always_comb begin
      enable_next = enable_reg;
      clksel_next = clksel_reg;
      split_enable_next = split_enable_reg;
      run_in_debug_next = run_in_debug_reg;
      target_next = target_reg;
      int_enable_next = int_enable_reg;
      if (wr) begin
         case (idx)
            IDX_TIMER_CONTROL: begin
               enable_next = wdata[BIT_ENABLE];
               clksel_next = wdata[CLKSEL_LSB+2:CLKSEL_LSB];
            end
            IDX_SPLIT_CONFIG: begin
               split_enable_next = wdata[BIT_SPLIT_ENABLE];
            end
            IDX_DEBUG_CONTROL: begin
               run_in_debug_next = wdata[BIT_RUN_IN_DEBUG];
            end
            default: begin
               enable_next = enable_reg;
            end
         endcase
         if (split_map) begin
            case (idx)
               IDX_COMMAND_CLEAR_VIEW: begin
                  target_next = target_reg
                     & ~wdata[TARGET_LSB+1:TARGET_LSB];
               end
               IDX_COMMAND_SET_VIEW: begin
                  target_next = target_reg
                     | wdata[TARGET_LSB+1:TARGET_LSB];
               end
               IDX_INTERRUPT_ENABLE: begin
                  int_enable_next = wdata & INTERRUPT_BIT_MASK;
               end
               default: begin
                  target_next = target_reg;
               end
            endcase
         end
      end
   end

   // period and compare registers; hard reset returns them to reset
   always_comb begin
      low_period_next = low_period_reg;
      high_period_next = high_period_reg;
      for (int n = 0; n < COMPARE_CHANNELS; n++) begin
         compare_next[n] = compare_reg[n];
      end
      if (hard_reset_cmd) begin
         low_period_next = PERIOD_RESET;
         high_period_next = PERIOD_RESET;
         for (int n = 0; n < COMPARE_CHANNELS; n++) begin
            compare_next[n] = BYTE_RESET;
         end
      end else if (wr && split_map) begin
         if (idx == IDX_LOW_PERIOD) begin
            low_period_next = wdata;
         end
         if (idx == IDX_HIGH_PERIOD) begin
            high_period_next = wdata;
         end
         for (int n = 0; n < COMPARE_CHANNELS; n++) begin
            if (compare_hit(idx, n)) begin
               compare_next[n] = wdata;
            end
         end
      end
   end

   // sticky flags; a new event wins over a clear in the same cycle
   always_comb begin
      flag_set = BYTE_RESET;
      for (int n = 0; n < COMPARE_CHANNELS; n++) begin
         // compared every cycle the timer may count
         flag_set[BIT_LOW_COMPARE0+n] = running
            & (low_count == compare_reg[n]);
      end
      flag_set[BIT_HIGH_UNDERFLOW] = high_bottom;
      flag_set[BIT_LOW_UNDERFLOW] = low_bottom;
      flag_clear = BYTE_RESET;
      if (wr && split_map && idx == IDX_INTERRUPT_FLAGS) begin
         flag_clear = wdata & INTERRUPT_BIT_MASK;
      end
      if (hard_reset_cmd) begin
         flags_next = BYTE_RESET;
      end else begin
         flags_next = ((flags_reg & ~flag_clear) | flag_set)
            & INTERRUPT_BIT_MASK;
      end
      irq_next = {flags_reg[BIT_LOW_COMPARE0+2:BIT_LOW_COMPARE0],
                  flags_reg[BIT_HIGH_UNDERFLOW:BIT_LOW_UNDERFLOW]}
               & {int_enable_reg[BIT_LOW_COMPARE0+2:BIT_LOW_COMPARE0],
                  int_enable_reg[BIT_HIGH_UNDERFLOW:BIT_LOW_UNDERFLOW]};
   end

   // prescaler restarts with a restart command so both timers realign
   always_comb begin
      if (!running || restart_cmd || hard_reset_cmd) begin
         prescale_next = PRESCALE_RESET;
      end else begin
         prescale_next = prescale_reg + 10'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_state_reg <= BUS_IDLE;
         readdata_reg <= READ_RESET;
         enable_reg <= 1'b0;
         clksel_reg <= 3'h0;
         split_enable_reg <= 1'b0;
         run_in_debug_reg <= 1'b0;
         target_reg <= TARGET_NONE;
         int_enable_reg <= BYTE_RESET;
         flags_reg <= BYTE_RESET;
         low_period_reg <= PERIOD_RESET;
         high_period_reg <= PERIOD_RESET;
         for (int n = 0; n < COMPARE_CHANNELS; n++) begin
            compare_reg[n] <= BYTE_RESET;
         end
         prescale_reg <= PRESCALE_RESET;
         irq_reg <= 5'h00;
      end else begin
         bus_state_reg <= bus_state_next;
         readdata_reg <= readdata_next;
         enable_reg <= enable_next;
         clksel_reg <= clksel_next;
         split_enable_reg <= split_enable_next;
         run_in_debug_reg <= run_in_debug_next;
         target_reg <= target_next;
         int_enable_reg <= int_enable_next;
         flags_reg <= flags_next;
         low_period_reg <= low_period_next;
         high_period_reg <= high_period_next;
         for (int n = 0; n < COMPARE_CHANNELS; n++) begin
            compare_reg[n] <= compare_next[n];
         end
         prescale_reg <= prescale_next;
         irq_reg <= irq_next;
      end
   end

   // the two byte timers share clock, reset, tick, commands and write data; period and write enable are separate
   byte_down_counter low_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick(tick),
      .clear(restart_cmd | hard_reset_cmd),
      .period(low_period_reg),
      .wr_en(wr && split_map && idx == IDX_LOW_COUNTER),
      .wr_data(wdata),
      .count(low_count),
      .bottom(low_bottom)
   );

   byte_down_counter high_timer (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick(tick),
      .clear(restart_cmd | hard_reset_cmd),
      .period(high_period_reg),
      .wr_en(wr && split_map && idx == IDX_HIGH_COUNTER),
      .wr_data(wdata),
      .count(high_count),
      .bottom(high_bottom)
   );

   assign avs_readdata = readdata_reg;
   assign low_counter_value = low_count;
   assign high_counter_value = high_count;
   assign interrupt_request = irq_reg;

endmodule : split_mode_dual_byte_timer_ctrl

// ==== split_timer_checker_assertions.sv ====
// concurrent checks on the ports of the split-mode dual byte timer
`timescale 1ns/10ps
module split_timer_checker
   import split_timer_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // debug and status
   input wire logic cpu_debug_halted,
   input wire logic [7:0] low_counter_value,
   input wire logic [7:0] high_counter_value,
   input wire logic [4:0] interrupt_request
);
   logic any_done;
   logic wr_done;
   logic live;
   logic [5:0] idx;
   logic split_reg, split_next, run_reg, run_next, dbg_reg, dbg_next;
   assign any_done = avs_write && !avs_waitrequest;
   assign wr_done = any_done && avs_byteenable[0];
   assign idx = avs_address[7:2];
   // run_reg tracks enable with div1 only; other rates are not stepped
   assign live = split_reg && run_reg && (!cpu_debug_halted || dbg_reg);
   always_comb begin
      split_next = split_reg;
      run_next = run_reg;
      dbg_next = dbg_reg;
      if (wr_done && idx == IDX_SPLIT_CONFIG) split_next = avs_writedata[0];
      if (wr_done && idx == IDX_TIMER_CONTROL)
         run_next = (avs_writedata[3:0] == 4'h1);
      if (wr_done && idx == IDX_DEBUG_CONTROL) dbg_next = avs_writedata[0];
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         split_reg <= 1'h0;
         run_reg <= 1'h0;
         dbg_reg <= 1'h0;
      end else begin
         split_reg <= split_next;
         run_reg <= run_next;
         dbg_reg <= dbg_next;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   a_wait_first: assert property ($rose(avs_read || avs_write)
      |-> avs_waitrequest) else $error("no wait state on new request");
   a_one_wait: assert property ((avs_read || avs_write)
      && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");
   a_reset_zero: assert property ($past(srst)
      |-> low_counter_value == 8'h00 && high_counter_value == 8'h00
      && interrupt_request == 5'h00)
      else $error("counters or irq not zero after reset");
   a_low_write: assert property (wr_done && split_reg
      && idx == IDX_LOW_COUNTER
      |=> low_counter_value == $past(avs_writedata[7:0]))
      else $error("low counter write lost");
   a_high_write: assert property (wr_done && split_reg
      && idx == IDX_HIGH_COUNTER
      |=> high_counter_value == $past(avs_writedata[7:0]))
      else $error("high counter write lost");
   a_cmd_reads_zero: assert property (avs_read && !avs_waitrequest
      && split_reg && (idx == IDX_COMMAND_CLEAR_VIEW
      || idx == IDX_COMMAND_SET_VIEW) |-> avs_readdata[3:2] == 2'h0)
      else $error("command field reads nonzero");
   a_count_step: assert property (live
      && low_counter_value != 8'h00 && !any_done
      |=> low_counter_value == $past(low_counter_value) - 8'h01)
      else $error("low counter did not step down");
   a_halt_hold: assert property (cpu_debug_halted && !dbg_reg
      && !any_done |=> $stable(low_counter_value)
      && $stable(high_counter_value))
      else $error("counter moved in debug halt");
   a_irq_sticky: assert property (!any_done && !$past(any_done)
      |=> ($past(interrupt_request) & ~interrupt_request) == 5'h00)
      else $error("interrupt dropped without write");
   c_low_write: cover property (wr_done && split_reg && idx == IDX_LOW_COUNTER);
   c_irq_seen: cover property (interrupt_request != 5'h00);
   c_debug_run: cover property (cpu_debug_halted && live);
endmodule : split_timer_checker
bind split_mode_dual_byte_timer_ctrl split_timer_checker u_chk (.sys_clk,
   .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_debug_halted,
   .low_counter_value, .high_counter_value, .interrupt_request);

// ==== split_mode_dual_byte_timer_ctrl_tb_top.sv ====
// self-checking testbench for the split-mode dual byte timer
`timescale 1ns/10ps
module split_mode_dual_byte_timer_ctrl_tb_top
   import split_timer_pkg::*;
;
   logic sys_clk = 1'h0;
   logic srst = 1'h1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic cpu_debug_halted = 1'h0;
   logic [7:0] low_counter_value, high_counter_value;
   logic [4:0] interrupt_request;
   logic [31:0] rd, rd_a;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   split_mode_dual_byte_timer_ctrl u_dut (.sys_clk, .srst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .cpu_debug_halted, .low_counter_value,
      .high_counter_value, .interrupt_request);
   always #5 sys_clk = ~sys_clk;
   task automatic finish_test();
      if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // the run should need well under 2000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one idle edge first, so a release and a new raise never share a step
   task automatic xfer(input logic w, input logic [5:0] idx,
                       input logic [7:0] d);
      @(posedge sys_clk);
      avs_address <= {idx, 2'h0};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h000000, d};
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'h0) @(posedge sys_clk);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : xfer
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      xfer(1'h1, idx, d);
   endtask : wr
   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      xfer(1'h0, idx, 8'h00);
      check($sformatf("reg %h", idx), rd, {24'h000000, exp});
   endtask : rdc
   task automatic t_layout();
      rdc(IDX_LOW_PERIOD, 8'h00);
      wr(IDX_LOW_COUNTER, 8'h55);
      wr(IDX_SPLIT_CONFIG, 8'h01);
      rdc(IDX_SPLIT_CONFIG, 8'h01);
      rdc(IDX_LOW_COUNTER, 8'h00);
      rdc(IDX_LOW_PERIOD, 8'hFF);
      rdc(IDX_HIGH_PERIOD, 8'hFF);
      rdc(IDX_HIGH_COUNTER, 8'h00);
      rdc(IDX_INTERRUPT_ENABLE, 8'h00);
      rdc(IDX_INTERRUPT_FLAGS, 8'h00);
      rdc(6'h06, 8'h00);
   endtask : t_layout
   task automatic t_counters();
      wr(IDX_LOW_COUNTER, 8'h55);
      rdc(IDX_LOW_COUNTER, 8'h55);
      avs_byteenable <= 4'h0;
      wr(IDX_LOW_COUNTER, 8'h11);
      avs_byteenable <= 4'hF;
      rdc(IDX_LOW_COUNTER, 8'h55);
      wr(IDX_HIGH_COUNTER, 8'hAA);
      rdc(IDX_HIGH_COUNTER, 8'hAA);
      check("high port", high_counter_value, 32'h0000_00AA);
   endtask : t_counters
   task automatic t_views();
      wr(IDX_COMMAND_SET_VIEW, 8'h03);
      rdc(IDX_COMMAND_SET_VIEW, 8'h03);
      wr(IDX_COMMAND_CLEAR_VIEW, 8'h01);
      rdc(IDX_COMMAND_SET_VIEW, 8'h02);
      wr(IDX_COMMAND_SET_VIEW, 8'h04);
      rdc(IDX_COMMAND_CLEAR_VIEW, 8'h02);
      wr(IDX_COMMAND_CLEAR_VIEW, 8'h0F);
      rdc(IDX_COMMAND_SET_VIEW, 8'h00);
   endtask : t_views
   task automatic t_commands();
      wr(IDX_LOW_COUNTER, 8'h44);
      wr(IDX_COMMAND_SET_VIEW, 8'h08);
      rdc(IDX_LOW_COUNTER, 8'h44);
      wr(IDX_COMMAND_CLEAR_VIEW, 8'h08);
      wr(IDX_COMMAND_SET_VIEW, 8'h0B); // both selected
      rdc(IDX_LOW_COUNTER, 8'h00);
      rdc(IDX_HIGH_COUNTER, 8'h00);
      wr(IDX_LOW_PERIOD, 8'h05);
      wr(IDX_TIMER_CONTROL, 8'h01);
      wr(IDX_COMMAND_SET_VIEW, 8'h0F);
      rdc(IDX_LOW_PERIOD, 8'h05);
      wr(IDX_TIMER_CONTROL, 8'h00);
      wr(IDX_COMMAND_SET_VIEW, 8'h0F);
      rdc(IDX_LOW_PERIOD, 8'hFF);
      rdc(IDX_LOW_COUNTER, 8'h00);
   endtask : t_commands
   task automatic t_flags();
      wr(IDX_LOW_PERIOD, 8'h03);
      wr(IDX_LOW_COMPARE0, 8'h01);
      wr(IDX_LOW_COMPARE0 + IDX_COMPARE_STRIDE, 8'h80);
      wr(IDX_LOW_COMPARE0 + 6'h02 * IDX_COMPARE_STRIDE, 8'h80);
      wr(IDX_INTERRUPT_ENABLE, 8'h11);
      rdc(IDX_INTERRUPT_ENABLE, 8'h11);
      wr(IDX_TIMER_CONTROL, 8'h01);
      repeat (20) @(posedge sys_clk);
      wr(IDX_TIMER_CONTROL, 8'h00);
      rdc(IDX_INTERRUPT_FLAGS, 8'h13);
      check("irq", interrupt_request, 32'h0000_0005);
      repeat (10) @(posedge sys_clk);
      rdc(IDX_INTERRUPT_FLAGS, 8'h13);
      wr(IDX_INTERRUPT_FLAGS, 8'h01);
      rdc(IDX_INTERRUPT_FLAGS, 8'h12);
      wr(IDX_INTERRUPT_FLAGS, 8'h12);
      rdc(IDX_INTERRUPT_FLAGS, 8'h00);
   endtask : t_flags
   task automatic t_debug();
      wr(IDX_LOW_PERIOD, 8'hFF);
      cpu_debug_halted <= 1'h1;
      wr(IDX_TIMER_CONTROL, 8'h01);
      xfer(1'h0, IDX_LOW_COUNTER, 8'h00);
      rd_a = rd;
      rdc(IDX_LOW_COUNTER, rd_a[7:0]); // frozen while halted
      wr(IDX_DEBUG_CONTROL, 8'h01);
      xfer(1'h0, IDX_LOW_COUNTER, 8'h00);
      rd_a = rd;
      xfer(1'h0, IDX_LOW_COUNTER, 8'h00);
      check("debug run", 32'(rd !== rd_a), 32'h0000_0001);
      cpu_debug_halted <= 1'h0;
      wr(IDX_LOW_COUNTER, 8'h40);
      #1;
      check("low port", low_counter_value, 32'h0000_0040);
      wr(IDX_TIMER_CONTROL, 8'h00);
   endtask : t_debug
   // divide by two: prescaler restarts at enable, so 8 cycles give 4 ticks
   task automatic t_prescale();
      wr(IDX_LOW_COUNTER, 8'h80);
      wr(IDX_TIMER_CONTROL, 8'h03);
      #1;
      check("div2 start", low_counter_value, 32'h0000_0080);
      repeat (8) @(posedge sys_clk);
      #1;
      check("div2 step", low_counter_value, 32'h0000_007C);
      wr(IDX_TIMER_CONTROL, 8'h00);
   endtask : t_prescale
   initial begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'h0;
      t_layout();
      t_counters();
      t_views();
      t_commands();
      t_flags();
      t_debug();
      t_prescale();
      finish_test();
   end
endmodule : split_mode_dual_byte_timer_ctrl_tb_top
